// file: hw/fpmdcr_pkg.sv
// constants, field layout and types for the alarm mask and device configuration registers
package fpmdcr_pkg;

  localparam int          ADDR_W           = 8;
  localparam int          DATA_W           = 16;

  localparam logic [7:0]  ADDR_CLK_MASK    = 8'h48;
  localparam logic [7:0]  ADDR_PIN_MASK    = 8'h4b;
  localparam logic [7:0]  ADDR_DEV_CFG     = 8'h4c;
  localparam logic [7:0]  ADDR_GPIO_CFG    = 8'h4d;

  localparam logic [15:0] PIN_MASK_RST     = 16'h0780;
  localparam logic [15:0] PIN_MASK_WMASK   = 16'h7f80;
  localparam logic [15:0] DEV_CFG_RST      = 16'h0000;
  localparam logic [15:0] DEV_CFG_WMASK    = 16'h7b00;
  localparam logic [15:0] GPIO_CFG_RST     = 16'h0000;
  localparam logic [15:0] GPIO_CFG_WMASK   = 16'h7ffd;
  localparam logic [15:0] CLK_MASK_RST     = 16'h0000;
  localparam logic [15:0] CLK_MASK_WMASK   = 16'h0007;

  localparam int          ALARM_FLAGS      = 8;
  localparam int          PM_LSB           = 7;
  localparam int          PM_RAIL_BIT      = 14;
  localparam int          PM_TIMING_BIT    = 13;
  localparam int          PM_LOGIC_BIT     = 12;
  localparam int          PM_OVERCUR_BIT   = 11;
  localparam int          PM_FRAME_BIT     = 10;
  localparam int          PM_IDLE_BIT      = 9;
  localparam int          PM_EDGE_BIT      = 8;
  localparam int          PM_ACCESS_BIT    = 7;

  localparam int          DC_OWNER_BIT     = 14;
  localparam int          DC_CLKSRC_BIT    = 12;
  localparam int          DC_WORD_BIT      = 11;
  localparam int          DC_PSTATE_LSB    = 8;

  localparam int          GPIO_PINS        = 5;
  localparam int          GP_FMT_LSB       = 10;
  localparam int          GP_DIR_LSB       = 5;
  localparam int          GP_SRC_LSB       = 0;
  localparam int          ALARM_PIN        = 2;

  localparam int          CLK_SUB_FLAGS    = 3;
  localparam logic [5:0]  WORD_BITS_SHORT  = 6'h18;
  localparam logic [5:0]  WORD_BITS_LONG   = 6'h20;

  typedef enum logic [1:0] {
    FPMDCR_ACTIVE    = 2'h0,
    FPMDCR_STANDBY   = 2'h1,
    FPMDCR_PDOWN     = 2'h2,
    FPMDCR_PDOWN_ALT = 2'h3
  } fpmdcr_pstate_t;

endpackage

// file: hw/fpmdcr_mask_or.sv
// masked or-reduction of a flag vector: high when any flag is set with its mask bit clear
`timescale 1ns/1ps
module fpmdcr_mask_or #(
  parameter int WIDTH = 8
) (
  input  wire logic [WIDTH-1:0] flags,
  input  wire logic [WIDTH-1:0] mask,
  output logic                  any_unmasked
);
  import fpmdcr_pkg::*;

  // mask bit one blocks its flag, zero lets it through
  assign any_unmasked = |(flags & ~mask);

endmodule

// file: hw/fpmdcr_regs.sv
// alarm pin mask, device configuration and general pin configuration registers
`timescale 1ns/1ps

// Function
// [RL1] mask bit 14 blocks power rail error
// [RL2] mask bit 13 blocks timing source error
// [RL3] mask bit 12 blocks logic integrity error
// [RL4] mask bit 11 blocks overcurrent alarm
// [RL5] mask bit 10 blocks frame check, reset one
// [RL6] mask bit 9 blocks idle expiry, reset one
// [RL7] mask bit 8 blocks edge tally, reset one
// [RL8] mask bit 7 blocks bad access, reset one
// [RL9] masks apply only in pin two alarm mode
// [RL10] mask reserved bits read zero, ignore writes
// [RL11] config bit 14 picks ready pin converter
// [RL12] config bit 12 picks clock source
// [RL13] host changes clock source only when idle
// [RL14] host keeps external clock during switch-over
// [RL15] config bit 11 selects 24 or 32 bit words
// [RL16] bits 9:8 select active, standby, power-down
// [RL17] pin config layout, resets to zero
// [RL18] timing error from individually masked sub-flags
// [RL19] alarm high while any unmasked flag active
// [RL20] mask change acts the cycle after write
module fpmdcr_regs (
  input  wire logic                          ref_clk,
  input  wire logic                          reset_n,
  input  wire logic [fpmdcr_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [fpmdcr_pkg::DATA_W-1:0] reg_wr_data,
  input  wire logic                          reg_wr_en,
  input  wire logic                          reg_rd_en,
  output logic      [fpmdcr_pkg::DATA_W-1:0] reg_rd_data_ff,
  input  wire logic                          power_rail_error,
  input  wire logic                          logic_integrity_error,
  input  wire logic                          overcurrent_alarm,
  input  wire logic                          serial_frame_check_error,
  input  wire logic                          serial_idle_expiry_error,
  input  wire logic                          serial_edge_tally_error,
  input  wire logic                          bad_register_access_error,
  input  wire logic                          main_clk_watchdog_error,
  input  wire logic                          diag_osc_watchdog_error,
  input  wire logic                          main_clk_freq_error,
  input  wire logic                          current_converter_a_done,
  input  wire logic                          current_converter_b_done,
  output logic                               timing_source_error_ff,
  output logic                               general_pin_two_alarm_ff,
  output logic                               general_pin_two_alarm_oe_ff,
  output logic                               conversion_ready_pin_n_ff,
  output logic                               ready_pin_owner_select_ff,
  output logic                               clock_source_external_ff,
  output logic      [5:0]                    frame_word_bits_ff,
  output fpmdcr_pkg::fpmdcr_pstate_t         power_state_select_ff,
  output logic                               converters_enable_ff,
  output logic      [fpmdcr_pkg::GPIO_PINS-1:0] pin_format_ff,
  output logic      [fpmdcr_pkg::GPIO_PINS-1:0] pin_direction_ff,
  output logic      [fpmdcr_pkg::GPIO_PINS-1:0] pin_source_ff
);
  import fpmdcr_pkg::*;

  logic [DATA_W-1:0]        pin_mask_ff;
  logic [DATA_W-1:0]        dev_cfg_ff;
  logic [DATA_W-1:0]        gpio_cfg_ff;
  logic [DATA_W-1:0]        clk_mask_ff;
  logic [DATA_W-1:0]        nxt_rd_data;
  logic [ALARM_FLAGS-1:0]   alarm_flags;
  logic [CLK_SUB_FLAGS-1:0] clk_sub_flags;
  logic                     alarm_any;
  logic                     timing_any;
  logic                     alarm_mode;
  logic                     wr_pin_mask;
  logic                     wr_dev_cfg;
  logic                     wr_gpio_cfg;
  logic                     wr_clk_mask;

  assign wr_pin_mask = reg_wr_en && (reg_addr == ADDR_PIN_MASK);
  assign wr_dev_cfg  = reg_wr_en && (reg_addr == ADDR_DEV_CFG);
  assign wr_gpio_cfg = reg_wr_en && (reg_addr == ADDR_GPIO_CFG);
  assign wr_clk_mask = reg_wr_en && (reg_addr == ADDR_CLK_MASK);

  // register storage
  // reserved bits are held at zero by the write mask, so reads see zero
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      pin_mask_ff <= PIN_MASK_RST; // [RL5] [RL6] [RL7] [RL8]
    end else if (wr_pin_mask) begin
      pin_mask_ff <= reg_wr_data & PIN_MASK_WMASK; // [RL10]
    end
  end

  // bit 13 is writable but unused; kept so software reads back what it wrote
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      dev_cfg_ff <= DEV_CFG_RST;
    end else if (wr_dev_cfg) begin
      dev_cfg_ff <= reg_wr_data & DEV_CFG_WMASK;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      gpio_cfg_ff <= GPIO_CFG_RST; // [RL17]
    end else if (wr_gpio_cfg) begin
      gpio_cfg_ff <= reg_wr_data & GPIO_CFG_WMASK; // [RL17]
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      clk_mask_ff <= CLK_MASK_RST;
    end else if (wr_clk_mask) begin
      clk_mask_ff <= reg_wr_data & CLK_MASK_WMASK; // [RL18]
    end
  end

  // register read port
  always_comb begin
    nxt_rd_data = '0;
    if (reg_rd_en) begin
      unique case (reg_addr)
        ADDR_PIN_MASK: nxt_rd_data = pin_mask_ff & PIN_MASK_WMASK; // [RL10]
        ADDR_DEV_CFG:  nxt_rd_data = dev_cfg_ff;
        ADDR_GPIO_CFG: nxt_rd_data = gpio_cfg_ff;
        ADDR_CLK_MASK: nxt_rd_data = clk_mask_ff;
        default:       nxt_rd_data = '0;
      endcase
    end
  end

  // read data stands for exactly one cycle, zero otherwise
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      reg_rd_data_ff <= '0;
    end else begin
      reg_rd_data_ff <= nxt_rd_data;
    end
  end

  // timing source error
  assign clk_sub_flags = {main_clk_freq_error, diag_osc_watchdog_error, main_clk_watchdog_error};

  fpmdcr_mask_or #(
    .WIDTH (CLK_SUB_FLAGS)
  ) u_clk_or (
    .flags        (clk_sub_flags),
    .mask         (clk_mask_ff[CLK_SUB_FLAGS-1:0]),
    .any_unmasked (timing_any)
  );

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      timing_source_error_ff <= 1'b0;
    end else begin
      timing_source_error_ff <= timing_any; // [RL18]
    end
  end

  // alarm pin
  // order follows mask bits 14 down to 7
  assign alarm_flags = {power_rail_error,           // [RL1]
                        timing_source_error_ff,     // [RL2]
                        logic_integrity_error,      // [RL3]
                        overcurrent_alarm,          // [RL4]
                        serial_frame_check_error,   // [RL5]
                        serial_idle_expiry_error,   // [RL6]
                        serial_edge_tally_error,    // [RL7]
                        bad_register_access_error}; // [RL8]

  // pin two serves as alarm when its source bit is set
  assign alarm_mode = gpio_cfg_ff[GP_SRC_LSB + ALARM_PIN];

  fpmdcr_mask_or #(
    .WIDTH (ALARM_FLAGS)
  ) u_alarm_or (
    .flags        (alarm_flags),
    .mask         (pin_mask_ff[PM_LSB +: ALARM_FLAGS]),
    .any_unmasked (alarm_any)
  );

  // masking gates only the pin; the flags themselves are never cleared here
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      general_pin_two_alarm_ff <= 1'b0;
    end else begin
      general_pin_two_alarm_ff <= alarm_mode && alarm_any; // [RL9] [RL19] [RL20]
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      general_pin_two_alarm_oe_ff <= 1'b0;
    end else begin
      general_pin_two_alarm_oe_ff <= alarm_mode; // [RL9]
    end
  end

  // device configuration outputs
  // the ready strobe follows only the selected converter, one cycle late
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      conversion_ready_pin_n_ff <= 1'b1;
    end else if (dev_cfg_ff[DC_OWNER_BIT]) begin
      conversion_ready_pin_n_ff <= !current_converter_b_done; // [RL11]
    end else begin
      conversion_ready_pin_n_ff <= !current_converter_a_done; // [RL11]
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      ready_pin_owner_select_ff <= 1'b0;
    end else begin
      ready_pin_owner_select_ff <= dev_cfg_ff[DC_OWNER_BIT]; // [RL11]
    end
  end

  // no interlock: switching safely is left to the host
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      clock_source_external_ff <= 1'b0;
    end else begin
      clock_source_external_ff <= dev_cfg_ff[DC_CLKSRC_BIT]; // [RL12] [RL13] [RL14]
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      frame_word_bits_ff <= WORD_BITS_SHORT;
    end else if (dev_cfg_ff[DC_WORD_BIT]) begin
      frame_word_bits_ff <= WORD_BITS_LONG; // [RL15]
    end else begin
      frame_word_bits_ff <= WORD_BITS_SHORT; // [RL15]
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      power_state_select_ff <= FPMDCR_ACTIVE;
    end else begin
      power_state_select_ff <= fpmdcr_pstate_t'(dev_cfg_ff[DC_PSTATE_LSB +: 2]); // [RL16]
    end
  end

  // converters run in active only; standby and both power-down codes stop them
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      converters_enable_ff <= 1'b1;
    end else begin
      unique case (fpmdcr_pstate_t'(dev_cfg_ff[DC_PSTATE_LSB +: 2]))
        FPMDCR_ACTIVE:    converters_enable_ff <= 1'b1; // [RL16]
        FPMDCR_STANDBY:   converters_enable_ff <= 1'b0; // [RL16]
        FPMDCR_PDOWN:     converters_enable_ff <= 1'b0; // [RL16]
        FPMDCR_PDOWN_ALT: converters_enable_ff <= 1'b0; // [RL16]
      endcase
    end
  end

  // general pin configuration outputs
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      pin_format_ff    <= '0;
      pin_direction_ff <= '0;
      pin_source_ff    <= '0;
    end else begin
      pin_format_ff    <= gpio_cfg_ff[GP_FMT_LSB +: GPIO_PINS]; // [RL17]
      pin_direction_ff <= gpio_cfg_ff[GP_DIR_LSB +: GPIO_PINS]; // [RL17]
      pin_source_ff    <= gpio_cfg_ff[GP_SRC_LSB +: GPIO_PINS]; // [RL17]
    end
  end

  // assertions
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  property p_rl1;
    (alarm_mode && alarm_flags == 8'h80 && pin_mask_ff[PM_RAIL_BIT])
      |=> !general_pin_two_alarm_ff;
  endproperty
  a_rl1: assert property (p_rl1) else $error("masked power rail error raised alarm"); // [RL1]

  property p_rl2;
    (alarm_mode && alarm_flags == 8'h40)
      |=> general_pin_two_alarm_ff == !$past(pin_mask_ff[PM_TIMING_BIT]);
  endproperty
  a_rl2: assert property (p_rl2) else $error("timing error mask misapplied"); // [RL2]

  property p_rl3;
    (alarm_mode && alarm_flags == 8'h20 && !pin_mask_ff[PM_LOGIC_BIT])
      |=> general_pin_two_alarm_ff;
  endproperty
  a_rl3: assert property (p_rl3) else $error("unmasked logic error gave no alarm"); // [RL3]

  property p_rl4;
    (alarm_mode && alarm_flags == 8'h10 && pin_mask_ff[PM_OVERCUR_BIT])
      |=> !general_pin_two_alarm_ff;
  endproperty
  a_rl4: assert property (p_rl4) else $error("masked overcurrent raised alarm"); // [RL4]

  property p_rl5_reset;
    disable iff (1'b0)
    !reset_n |=> (pin_mask_ff == PIN_MASK_RST && dev_cfg_ff == DEV_CFG_RST);
  endproperty
  a_rl5_reset: assert property (p_rl5_reset) else $error("mask reset value wrong"); // [RL5]

  property p_rl6;
    (alarm_mode && (alarm_flags & 8'h0f) != 8'h00 && (alarm_flags & 8'hf0) == 8'h00
      && pin_mask_ff[PM_FRAME_BIT:PM_ACCESS_BIT] == 4'hf) |=> !general_pin_two_alarm_ff;
  endproperty
  a_rl6: assert property (p_rl6) else $error("masked serial error raised alarm"); // [RL6]

  property p_rl9;
    !alarm_mode |=> (!general_pin_two_alarm_ff && !general_pin_two_alarm_oe_ff);
  endproperty
  a_rl9: assert property (p_rl9) else $error("alarm driven outside alarm mode"); // [RL9]

  property p_rl10;
    (reg_rd_en && reg_addr == ADDR_PIN_MASK)
      |=> (reg_rd_data_ff[15] == 1'b0 && reg_rd_data_ff[6:0] == 7'h00);
  endproperty
  a_rl10: assert property (p_rl10) else $error("reserved mask bits read nonzero"); // [RL10]

  property p_rl11;
    (dev_cfg_ff[DC_OWNER_BIT] && current_converter_b_done) |=> !conversion_ready_pin_n_ff;
  endproperty
  a_rl11: assert property (p_rl11) else $error("ready pin missed converter b"); // [RL11]

  sequence s_word_long_write;
    wr_dev_cfg && reg_wr_data[DC_WORD_BIT] ##1 !wr_dev_cfg;
  endsequence
  property p_rl15;
    s_word_long_write |=> frame_word_bits_ff == WORD_BITS_LONG;
  endproperty
  a_rl15: assert property (p_rl15) else $error("word length not 32 after write"); // [RL15]

  property p_rl16;
    (dev_cfg_ff[DC_PSTATE_LSB +: 2] != 2'h0) |=> !converters_enable_ff;
  endproperty
  a_rl16: assert property (p_rl16) else $error("converters enabled outside active"); // [RL16]

  property p_rl18;
    (clk_sub_flags != 3'h0 && (clk_sub_flags & ~clk_mask_ff[2:0]) == 3'h0)
      |=> !timing_source_error_ff;
  endproperty
  a_rl18: assert property (p_rl18) else $error("masked clock sub-flag set timing error"); // [RL18]

  sequence s_unmask_all;
    wr_pin_mask && reg_wr_data == 16'h0000;
  endsequence
  property p_rl20;
    s_unmask_all ##1 (alarm_mode && alarm_flags != 8'h00) |=> general_pin_two_alarm_ff;
  endproperty
  a_rl20: assert property (p_rl20) else $error("unmask did not take effect next cycle"); // [RL20]

endmodule

// file: verification/fpmdcr_host.sv
// host side model: drives the register port one strobe at a time
`timescale 1ns/1ps
module fpmdcr_host (
  input  wire logic                          ref_clk,
  output logic      [fpmdcr_pkg::ADDR_W-1:0] reg_addr,
  output logic      [fpmdcr_pkg::DATA_W-1:0] reg_wr_data,
  output logic                               reg_wr_en,
  output logic                               reg_rd_en,
  input  wire logic [fpmdcr_pkg::DATA_W-1:0] reg_rd_data_ff
);
  import fpmdcr_pkg::*;
  initial begin
    reg_addr    = 8'h00;
    reg_wr_data = 16'h0000;
    reg_wr_en   = 1'b0;
    reg_rd_en   = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_addr    <= a;
    reg_wr_data <= d;
    reg_wr_en   <= 1'b1;
    @(posedge ref_clk);
    reg_wr_en   <= 1'b0;
    // released lines show the inverse so a stale copy is never trusted
    reg_addr    <= ~a;
    reg_wr_data <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_rd_en <= 1'b1;
    @(posedge ref_clk);
    reg_rd_en <= 1'b0;
    reg_addr  <= ~a;
    #1;
    d = reg_rd_data_ff;
  endtask
  // source flips only while parked in standby, then the old clock keeps running a while
  task automatic set_clk_src(input logic [15:0] cfg, input logic ext);
    wr(ADDR_DEV_CFG, (cfg & 16'hfcff) | 16'h0100);
    wr(ADDR_DEV_CFG, (cfg & 16'hecff) | 16'h0100 | {3'h0, ext, 12'h000});
    repeat (8) @(posedge ref_clk);
    wr(ADDR_DEV_CFG, (cfg & 16'hefff) | {3'h0, ext, 12'h000});
  endtask
endmodule

// file: verification/fpmdcr_regs_tb.sv
// self-checking bench for the alarm mask and device configuration registers
`timescale 1ns/1ps
module fpmdcr_regs_tb;
  import fpmdcr_pkg::*;
  logic           ref_clk, reset_n, wr_en, rd_en, a_done, b_done;
  logic [7:0]     addr, flg;
  logic [15:0]    wdata, rdata, v;
  logic [2:0]     sub;
  logic           ts_err, alarm, alarm_oe, ready_n, owner, clk_ext, conv_en;
  logic [5:0]     word_bits;
  fpmdcr_pstate_t pstate;
  logic [4:0]     pin_fmt, pin_dir, pin_src;
  int             mismatches, n_tests;

  fpmdcr_host host (.ref_clk(ref_clk), .reg_addr(addr), .reg_wr_data(wdata),
    .reg_wr_en(wr_en), .reg_rd_en(rd_en), .reg_rd_data_ff(rdata));
  fpmdcr_regs uut (.ref_clk(ref_clk), .reset_n(reset_n), .reg_addr(addr),
    .reg_wr_data(wdata), .reg_wr_en(wr_en), .reg_rd_en(rd_en), .reg_rd_data_ff(rdata),
    .power_rail_error(flg[7]), .logic_integrity_error(flg[5]), .overcurrent_alarm(flg[4]),
    .serial_frame_check_error(flg[3]), .serial_idle_expiry_error(flg[2]),
    .serial_edge_tally_error(flg[1]), .bad_register_access_error(flg[0]),
    .main_clk_watchdog_error(sub[0]), .diag_osc_watchdog_error(sub[1]),
    .main_clk_freq_error(sub[2]), .current_converter_a_done(a_done),
    .current_converter_b_done(b_done), .timing_source_error_ff(ts_err),
    .general_pin_two_alarm_ff(alarm), .general_pin_two_alarm_oe_ff(alarm_oe),
    .conversion_ready_pin_n_ff(ready_n), .ready_pin_owner_select_ff(owner),
    .clock_source_external_ff(clk_ext), .frame_word_bits_ff(word_bits),
    .power_state_select_ff(pstate), .converters_enable_ff(conv_en),
    .pin_format_ff(pin_fmt), .pin_direction_ff(pin_dir), .pin_source_ff(pin_src));

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [15:0] exp);
    host.rd(a, v);
    chk(v, exp);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic pulse(input logic b);
    @(posedge ref_clk);
    if (b) b_done <= 1'b1;
    else a_done <= 1'b1;
    @(posedge ref_clk);
    a_done <= 1'b0;
    b_done <= 1'b0;
    #1;
  endtask

  task automatic t_reset();
    rchk(ADDR_PIN_MASK, 16'h0780);
    rchk(ADDR_DEV_CFG, 16'h0000);
    rchk(ADDR_GPIO_CFG, 16'h0000);
    chk({10'h000, word_bits}, 16'h0018);
    chk({15'h0000, conv_en}, 16'h0001);
    chk({15'h0000, alarm_oe}, 16'h0000);
    $display("test reset values done");
  endtask

  task automatic t_access();
    host.wr(ADDR_PIN_MASK, 16'hffff);
    rchk(ADDR_PIN_MASK, 16'h7f80);
    host.wr(ADDR_DEV_CFG, 16'hefff);
    rchk(ADDR_DEV_CFG, 16'h6b00);
    host.wr(ADDR_GPIO_CFG, 16'hfffb);
    rchk(ADDR_GPIO_CFG, 16'h7ff9);
    chk({1'b0, pin_fmt, pin_dir, pin_src}, 16'h7ff9);
    host.wr(8'h4a, 16'hffff);
    rchk(8'h4a, 16'h0000);
    host.wr(ADDR_DEV_CFG, 16'h0000);
    host.wr(ADDR_GPIO_CFG, 16'h0000);
    $display("test access kinds done");
  endtask

  task automatic t_alarm();
    host.wr(ADDR_GPIO_CFG, 16'h0004);
    host.wr(ADDR_PIN_MASK, 16'h0000);
    cyc(2);
    chk({15'h0000, alarm_oe}, 16'h0001);
    for (int i = 0; i < 8; i++) begin
      @(posedge ref_clk);
      if (i == 6) sub <= 3'h1;
      else flg[i] <= 1'b1;
      cyc(3);
      chk({15'h0000, alarm}, 16'h0001);
      host.wr(ADDR_PIN_MASK, 16'h0080 << i);
      cyc(2);
      chk({15'h0000, alarm}, 16'h0000);
      host.wr(ADDR_PIN_MASK, 16'h0000);
      cyc(1);
      chk({15'h0000, alarm}, 16'h0001);
      @(posedge ref_clk);
      flg <= 8'h00;
      sub <= 3'h0;
      cyc(3);
      chk({15'h0000, alarm}, 16'h0000);
    end
    // pin two as a plain pin: an unmasked flag must stay off the alarm
    @(posedge ref_clk);
    flg <= 8'h80;
    host.wr(ADDR_GPIO_CFG, 16'h0000);
    cyc(2);
    chk({15'h0000, alarm}, 16'h0000);
    chk({15'h0000, alarm_oe}, 16'h0000);
    @(posedge ref_clk);
    flg <= 8'h00;
    $display("test alarm masking done");
  endtask

  // reset in mid-run must bring back the defaults, serial errors masked again
  task automatic t_rereset();
    host.wr(ADDR_PIN_MASK, 16'h4000);
    host.wr(ADDR_DEV_CFG, 16'h4900);
    host.wr(ADDR_GPIO_CFG, 16'h0004);
    @(posedge ref_clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    rchk(ADDR_PIN_MASK, 16'h0780);
    rchk(ADDR_DEV_CFG, 16'h0000);
    rchk(ADDR_GPIO_CFG, 16'h0000);
    chk({15'h0000, owner}, 16'h0000);
    chk({10'h000, word_bits}, 16'h0018);
    chk({15'h0000, alarm_oe}, 16'h0000);
    host.wr(ADDR_GPIO_CFG, 16'h0004);
    @(posedge ref_clk);
    flg <= 8'h0f;
    cyc(3);
    chk({15'h0000, alarm}, 16'h0000);
    host.wr(ADDR_PIN_MASK, 16'h0000);
    cyc(1);
    chk({15'h0000, alarm}, 16'h0001);
    @(posedge ref_clk);
    flg <= 8'h00;
    host.wr(ADDR_GPIO_CFG, 16'h0000);
    $display("test reset in mid-run done");
  endtask

  task automatic t_timing();
    for (int i = 0; i < 3; i++) begin
      @(posedge ref_clk);
      sub <= 3'h1 << i;
      cyc(2);
      chk({15'h0000, ts_err}, 16'h0001);
      host.wr(ADDR_CLK_MASK, 16'h0001 << i);
      cyc(2);
      chk({15'h0000, ts_err}, 16'h0000);
      host.wr(ADDR_CLK_MASK, 16'h0000);
      @(posedge ref_clk);
      sub <= 3'h0;
    end
    $display("test timing sub-flags done");
  endtask

  task automatic t_devcfg();
    pulse(1'b0);
    chk({15'h0000, ready_n}, 16'h0000);
    pulse(1'b1);
    chk({15'h0000, ready_n}, 16'h0001);
    host.wr(ADDR_DEV_CFG, 16'h4000);
    cyc(2);
    chk({15'h0000, owner}, 16'h0001);
    pulse(1'b1);
    chk({15'h0000, ready_n}, 16'h0000);
    pulse(1'b0);
    chk({15'h0000, ready_n}, 16'h0001);
    host.wr(ADDR_DEV_CFG, 16'h0800);
    cyc(2);
    chk({10'h000, word_bits}, 16'h0020);
    for (int s = 0; s < 4; s++) begin
      host.wr(ADDR_DEV_CFG, {6'h00, 2'(s), 8'h00});
      cyc(2);
      chk({14'h0000, pstate}, 16'(s));
      chk({15'h0000, conv_en}, {15'h0000, s == 0});
    end
    host.set_clk_src(16'h0000, 1'b1);
    cyc(2);
    chk({15'h0000, clk_ext}, 16'h0001);
    rchk(ADDR_DEV_CFG, 16'h1000);
    host.set_clk_src(16'h1000, 1'b0);
    cyc(2);
    chk({15'h0000, clk_ext}, 16'h0000);
    $display("test device configuration done");
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    repeat (4000) @(posedge ref_clk);
    mismatches++;
    summarize();
  end

  initial begin
    mismatches = 0;
    n_tests    = 0;
    reset_n    = 1'b0;
    flg        = 8'h00;
    sub        = 3'h0;
    a_done     = 1'b0;
    b_done     = 1'b0;
    repeat (4) @(posedge ref_clk);
    reset_n <= 1'b1;
    t_reset();
    t_access();
    t_alarm();
    t_timing();
    t_devcfg();
    t_rereset();
    summarize();
  end
endmodule
